// [pcstack.sv]
// Program counter, return stack and arithmetic status flags of the core
//
// Summary of operation
// - Status writes cannot change flags the same instruction computes itself.
// - Watchdog expiry and sleep entered status bits are never writable.
// - Subtraction reports carry and digit carry as inverted borrows.
// - Program counter is 15 bits; low byte accessible, upper from latch.
// - Every reset clears the whole program counter.
// - Writing the low byte also loads upper bits from the latch.
// - Call loads operand into bits 10:0 and latch bits 6:3 above.
// - Computed call forms target from latch and accumulator.
// - Jump by accumulator goes to address plus one plus unsigned value.
// - Literal jump goes to address plus one plus signed operand.
// - Return stack holds sixteen 15-bit entries outside memory spaces.
// - Calls and interrupts push; returns pop; latch stays untouched.
// - Without fault reset the stack wraps, overwriting oldest entries.
// - Overflow and underflow flags set in both stack modes.
// - With fault reset enabled, stack overflow or underflow resets device.
// - Software selects an entry by pointer and accesses it as two bytes.
// - Stack pointer is five bits wide to mark the empty stack.
// - Push increments then stores; pop reads then decrements.
// - Result null flag is set exactly when the result is zero.
// - Add and subtract spill flags come from bit 3 and bit 7.
`timescale 1ns/1ns

module pcstack
   import pcstack_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic [12:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [7:0] reg_rdata_o,
   input wire logic op_valid_i,
   input wire pc_op_t op_i,
   input wire logic [10:0] operand_i,
   input wire logic [7:0] acc_i,
   input wire alu_op_t alu_op_i,
   input wire logic [7:0] alu_a_i,
   input wire logic [7:0] alu_b_i,
   input wire logic [7:0] logic_res_i,
   input wire logic clrwdt_i,
   input wire logic sleep_i,
   input wire logic wdt_timeout_i,
   input wire logic stack_fault_reset_en_i,
   output logic [14:0] program_counter_o,
   output logic [6:0] upper_counter_latch_o,
   output logic [4:0] status_o,
   output logic [4:0] stack_pointer_o,
   output logic [7:0] alu_result_o,
   output logic device_reset_o
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [14:0] pc;
      logic [6:0] latch;
      logic [4:0] status;
      logic [4:0] sp;
      logic [15:0][14:0] stk;
      logic ovf;
      logic unf;
      logic [7:0] rdata;
      logic [7:0] alu_res;
      logic fault_rst;
   } state_t;

   state_t q;
   state_t d;

   logic push;
   logic pop;
   logic over;
   logic under;
   logic [4:0] sp_inc;
   logic [4:0] sp_dec;
   logic [14:0] ret_addr;
   logic [7:0] b_eff;
   logic cin;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] res;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      d = q;
      d.rdata = 8'h00;
      d.fault_rst = 1'b0;
      sp_inc = q.sp + 5'h01;
      sp_dec = q.sp - 5'h01;
      ret_addr = q.pc + 15'h0001;
      push = op_valid_i && (op_i == OP_CALL || op_i == OP_COMPUTED_CALL ||
                            op_i == OP_INT_VECTOR);
      pop = op_valid_i && (op_i == OP_RETURN ||
                           op_i == OP_RETURN_WITH_LITERAL ||
                           op_i == OP_RETURN_FROM_INTERRUPT);
      over = push && (q.sp == SP_TOP);
      under = pop && (q.sp == SP_EMPTY);
      cin = (alu_op_i == ALU_SUB);
      b_eff = cin ? ~alu_b_i : alu_b_i;
      sum = {1'b0, alu_a_i} + {1'b0, b_eff} + {8'h00, cin};
      nib = {1'b0, alu_a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
      res = (alu_op_i == ALU_LOGIC) ? logic_res_i : sum[7:0];

      // Program counter and stack movement
      if (op_valid_i) begin
         case (op_i)
            OP_HOLD: begin
               d.pc = q.pc;
            end
            OP_STEP: begin
               d.pc = ret_addr;
            end
            OP_CALL: begin
               d.pc = {q.latch[6:3], operand_i};
            end
            OP_COMPUTED_CALL: begin
               d.pc = {q.latch, acc_i};
            end
            OP_INT_VECTOR: begin
               d.pc = INT_VECTOR;
            end
            OP_RETURN, OP_RETURN_WITH_LITERAL,
            OP_RETURN_FROM_INTERRUPT: begin
               d.pc = q.stk[q.sp[3:0]];
            end
            OP_RELATIVE_JUMP_BY_ACC: begin
               d.pc = ret_addr + {7'h00, acc_i};
            end
            OP_RELATIVE_JUMP_LITERAL: begin
               d.pc = ret_addr + {{6{operand_i[8]}}, operand_i[8:0]};
            end
            default: begin
               d.pc = q.pc;
            end
         endcase
      end
      if (push) begin
         d.sp = {1'b0, sp_inc[3:0]};
         if (op_i == OP_INT_VECTOR) begin
            d.stk[sp_inc[3:0]] = q.pc;
         end else begin
            d.stk[sp_inc[3:0]] = ret_addr;
         end
      end
      if (pop) begin
         d.sp = under ? {1'b0, sp_dec[3:0]} : sp_dec;
      end

      // Register writes
      if (reg_we_i) begin
         case (reg_addr_i)
            ADDR_LOWER_BYTE: begin
               d.pc = {q.latch, reg_wdata_i};
            end
            ADDR_STATUS: begin
               d.status[ST_RESULT_NULL] = reg_wdata_i[ST_RESULT_NULL];
               d.status[ST_NIBBLE_SPILL] = reg_wdata_i[ST_NIBBLE_SPILL];
               d.status[ST_MSB_SPILL] = reg_wdata_i[ST_MSB_SPILL];
            end
            ADDR_UPPER_LATCH: begin
               d.latch = reg_wdata_i[6:0];
            end
            ADDR_STACK_POINTER: begin
               d.sp = reg_wdata_i[4:0];
            end
            ADDR_STACK_TOP_LOWER: begin
               d.stk[q.sp[3:0]][7:0] = reg_wdata_i;
            end
            ADDR_STACK_TOP_UPPER: begin
               d.stk[q.sp[3:0]][14:8] = reg_wdata_i[6:0];
            end
            ADDR_STACK_FLAGS: begin
               d.ovf = q.ovf & reg_wdata_i[SF_OVERFLOW];
               d.unf = q.unf & reg_wdata_i[SF_UNDERFLOW];
            end
            default: begin
               d.latch = q.latch;
            end
         endcase
      end

      // Flags computed by the operation override any written value
      if (alu_op_i != ALU_NONE) begin
         d.alu_res = res;
         d.status[ST_RESULT_NULL] = (res == 8'h00);
         if (alu_op_i != ALU_LOGIC) begin
            d.status[ST_MSB_SPILL] = sum[8];
            d.status[ST_NIBBLE_SPILL] = nib[4];
         end
      end

      // Power state bits change only by hardware events
      if (clrwdt_i) begin
         d.status[ST_WATCHDOG_EXPIRY] = 1'b1;
         d.status[ST_SLEEP_ENTERED] = 1'b1;
      end else if (sleep_i) begin
         d.status[ST_WATCHDOG_EXPIRY] = 1'b1;
         d.status[ST_SLEEP_ENTERED] = 1'b0;
      end
      if (wdt_timeout_i) begin
         d.status[ST_WATCHDOG_EXPIRY] = 1'b0;
      end

      // Fault flags set after the clear so the set wins
      if (over) begin
         d.ovf = 1'b1;
      end
      if (under) begin
         d.unf = 1'b1;
      end
      if ((over || under) && stack_fault_reset_en_i) begin
         d.pc = PC_RESET;
         d.sp = SP_EMPTY;
         d.fault_rst = 1'b1;
      end

      // Read data appear the cycle after the strobe
      if (reg_re_i) begin
         case (reg_addr_i)
            ADDR_LOWER_BYTE: d.rdata = q.pc[7:0];
            ADDR_STATUS: d.rdata = {3'h0, q.status};
            ADDR_UPPER_LATCH: d.rdata = {1'b0, q.latch};
            ADDR_STACK_POINTER: d.rdata = {3'h0, q.sp};
            ADDR_STACK_TOP_LOWER: d.rdata = q.stk[q.sp[3:0]][7:0];
            ADDR_STACK_TOP_UPPER: d.rdata = {1'b0, q.stk[q.sp[3:0]][14:8]};
            ADDR_STACK_FLAGS: d.rdata = {6'h00, q.unf, q.ovf};
            default: d.rdata = 8'h00;
         endcase
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q.pc <= PC_RESET;
         q.latch <= LATCH_RESET;
         q.status <= STATUS_RESET;
         q.sp <= SP_EMPTY;
         q.stk <= '0;
         q.ovf <= 1'b0;
         q.unf <= 1'b0;
         q.rdata <= 8'h00;
         q.alu_res <= 8'h00;
         q.fault_rst <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata_o = q.rdata;
   assign program_counter_o = q.pc;
   assign upper_counter_latch_o = q.latch;
   assign status_o = q.status;
   assign stack_pointer_o = q.sp;
   assign alu_result_o = q.alu_res;
   assign device_reset_o = q.fault_rst;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   sequence s_call;
      op_valid_i && op_i == OP_CALL && q.sp != SP_TOP && !reg_we_i;
   endsequence

   sequence s_return;
      op_valid_i && op_i == OP_RETURN && !reg_we_i;
   endsequence

   sequence s_over_fault;
      op_valid_i && op_i == OP_CALL && q.sp == SP_TOP &&
         stack_fault_reset_en_i;
   endsequence

   AST_LOWER_WRITE: assert property (
      reg_we_i && reg_addr_i == ADDR_LOWER_BYTE && !op_valid_i
      |=> q.pc == {$past(q.latch), $past(reg_wdata_i)})
      else $error("low byte write did not load upper bits from latch");

   AST_STATUS_RO: assert property (
      reg_we_i && reg_addr_i == ADDR_STATUS && !clrwdt_i && !sleep_i &&
         !wdt_timeout_i
      |=> q.status[4:3] == $past(q.status[4:3]))
      else $error("power state status bits changed by a write");

   AST_ADD_CARRY: assert property (
      alu_op_i == ALU_ADD
      |=> q.status[ST_MSB_SPILL] ==
         (({1'b0, $past(alu_a_i)} + {1'b0, $past(alu_b_i)}) > 9'h0FF))
      else $error("add carry flag wrong");

   AST_SUB_BORROW: assert property (
      alu_op_i == ALU_SUB
      |=> q.status[ST_MSB_SPILL] == ($past(alu_a_i) >= $past(alu_b_i)))
      else $error("subtract borrow flag has wrong polarity");

   AST_NULL_FLAG: assert property (
      alu_op_i != ALU_NONE
      |=> q.status[ST_RESULT_NULL] == ((($past(alu_op_i) == ALU_LOGIC) ?
         $past(logic_res_i) : ($past(alu_op_i) == ALU_ADD) ?
         $past(alu_a_i) + $past(alu_b_i) :
         $past(alu_a_i) - $past(alu_b_i)) == 8'h00))
      else $error("result null flag disagrees with result");

   AST_CALL_LOAD: assert property (
      s_call
      |=> q.pc == {$past(q.latch[6:3]), $past(operand_i)})
      else $error("call target wrong");

   AST_CALL_RETURN: assert property (
      s_call ##1 s_return
      |=> q.pc == $past(q.pc, 2) + 15'h0001 && q.sp == $past(q.sp, 2))
      else $error("return did not restore caller address and pointer");

   AST_BRW: assert property (
      op_valid_i && op_i == OP_RELATIVE_JUMP_BY_ACC && !reg_we_i
      |=> q.pc == $past(q.pc) + 15'h0001 + {7'h00, $past(acc_i)})
      else $error("jump by accumulator target wrong");

   AST_WRAP: assert property (
      op_valid_i && op_i == OP_CALL && q.sp == SP_TOP &&
         !stack_fault_reset_en_i && !reg_we_i
      |=> q.sp == 5'h00 && q.ovf && !device_reset_o)
      else $error("circular stack did not wrap with overflow flag");

   AST_FAULT_RESET: assert property (
      s_over_fault
      |=> device_reset_o && q.pc == PC_RESET && q.ovf ##1 !device_reset_o)
      else $error("stack overflow did not reset device");

endmodule

// [pcstack_pkg.sv]
// Constants and types shared by the program counter and call stack block
package pcstack_pkg;

   // ************************************************************
   // Register addresses
   // ************************************************************
   localparam int ADDR_W = 13;
   localparam logic [12:0] ADDR_LOWER_BYTE = 13'h0002;
   localparam logic [12:0] ADDR_STATUS = 13'h0003;
   localparam logic [12:0] ADDR_UPPER_LATCH = 13'h000A;
   localparam logic [12:0] ADDR_STACK_FLAGS = 13'h00F0;
   localparam logic [12:0] ADDR_STACK_POINTER = 13'h1FED;
   localparam logic [12:0] ADDR_STACK_TOP_LOWER = 13'h1FEE;
   localparam logic [12:0] ADDR_STACK_TOP_UPPER = 13'h1FEF;

   // ************************************************************
   // Status register fields
   // ************************************************************
   localparam int ST_MSB_SPILL = 0;
   localparam int ST_NIBBLE_SPILL = 1;
   localparam int ST_RESULT_NULL = 2;
   localparam int ST_SLEEP_ENTERED = 3;
   localparam int ST_WATCHDOG_EXPIRY = 4;
   localparam logic [4:0] STATUS_RESET = 5'h18;

   // Stack flag register fields
   localparam int SF_OVERFLOW = 0;
   localparam int SF_UNDERFLOW = 1;

   // ************************************************************
   // Sizes and reset values
   // ************************************************************
   localparam int PC_W = 15;
   localparam int STACK_DEPTH = 16;
   localparam logic [14:0] PC_RESET = 15'h0000;
   localparam logic [14:0] INT_VECTOR = 15'h0004;
   localparam logic [6:0] LATCH_RESET = 7'h00;
   localparam logic [4:0] SP_EMPTY = 5'h1F;
   localparam logic [4:0] SP_TOP = 5'h0F;

   // ************************************************************
   // Operations from the instruction decoder
   // ************************************************************
   typedef enum logic [3:0] {
      OP_HOLD,
      OP_STEP,
      OP_CALL,
      OP_COMPUTED_CALL,
      OP_INT_VECTOR,
      OP_RETURN,
      OP_RETURN_WITH_LITERAL,
      OP_RETURN_FROM_INTERRUPT,
      OP_RELATIVE_JUMP_BY_ACC,
      OP_RELATIVE_JUMP_LITERAL
   } pc_op_t;

   typedef enum logic [1:0] {
      ALU_NONE,
      ALU_ADD,
      ALU_SUB,
      ALU_LOGIC
   } alu_op_t;

endpackage

// [pcstack_bench.sv]
// Self-checking bench for the program counter and call stack block
`timescale 1ns/1ns

module pcstack_bench;
   import pcstack_pkg::*;

   // ************************************************************
   // Stimulus and design
   // ************************************************************
   logic ref_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [12:0] reg_addr_i = 13'h0000;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_we_i = 1'b0;
   logic reg_re_i = 1'b0;
   logic op_valid_i = 1'b0;
   pc_op_t op_i = OP_HOLD;
   logic [10:0] operand_i = 11'h000;
   logic [7:0] acc_i = 8'h80;
   alu_op_t alu_op_i = ALU_NONE;
   logic [7:0] alu_a_i = 8'h00;
   logic [7:0] alu_b_i = 8'h00;
   logic stack_fault_reset_en_i = 1'b0;
   logic [7:0] logic_res_i = 8'h00;
   logic clrwdt_i = 1'b0;
   logic sleep_i = 1'b0;
   logic wdt_timeout_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic [14:0] program_counter_o;
   logic [6:0] upper_counter_latch_o;
   logic [4:0] status_o;
   logic [4:0] stack_pointer_o;
   logic [7:0] alu_result_o;
   logic device_reset_o;
   int n_fail = 0;
   int total_checks = 0;
   int n_rst = 0;
   logic [7:0] v;

   pcstack u_pcstack (
      .ref_clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
      .reg_re_i, .reg_rdata_o, .op_valid_i, .op_i, .operand_i, .acc_i,
      .alu_op_i, .alu_a_i, .alu_b_i, .logic_res_i,
      .clrwdt_i, .sleep_i, .wdt_timeout_i,
      .stack_fault_reset_en_i, .program_counter_o, .upper_counter_latch_o,
      .status_o, .stack_pointer_o, .alu_result_o, .device_reset_o
   );

   always #20 ref_clk_i = ~ref_clk_i;

   // Counts device reset pulses from stack faults
   always @(posedge ref_clk_i) begin
      if (device_reset_o === 1'b1) begin
         n_rst <= n_rst + 1;
      end
   end

   // ************************************************************
   // Access tasks
   // ************************************************************
   task automatic chk(input logic [14:0] g, input logic [14:0] e,
                      input string m);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask

   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_we_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_we_i <= 1'b0;
      @(posedge ref_clk_i);
      #1;
   endtask

   task automatic rd(input logic [12:0] a, output logic [7:0] d);
      reg_addr_i <= a;
      reg_re_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_re_i <= 1'b0;
      #1;
      d = reg_rdata_o;
      @(posedge ref_clk_i);
      #1;
   endtask

   task automatic op(input pc_op_t o, input logic [10:0] x);
      op_i <= o;
      operand_i <= x;
      op_valid_i <= 1'b1;
      @(posedge ref_clk_i);
      op_valid_i <= 1'b0;
      @(posedge ref_clk_i);
      #1;
   endtask

   task automatic alu(input alu_op_t o, input logic [7:0] a,
                      input logic [7:0] b);
      alu_op_i <= o;
      alu_a_i <= a;
      alu_b_i <= b;
      @(posedge ref_clk_i);
      alu_op_i <= ALU_NONE;
      @(posedge ref_clk_i);
      #1;
   endtask

   task give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk_i);
      n_fail++;
      $display("unexpected at %0t: run did not finish", $time);
      give_verdict();
   end

   // ************************************************************
   // Test sequence
   // ************************************************************
   initial begin
      repeat (12) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      #1;
      chk(program_counter_o, 15'h0000, "pc after reset");
      rd(ADDR_STACK_POINTER, v);
      chk(v, 8'h1F, "pointer after reset");
      rd(ADDR_STATUS, v);
      chk(v, 8'h18, "status after reset");
      rd(13'h0100, v);
      chk(v, 8'h00, "unmapped read");
      $display("test reset done");
      wr(ADDR_UPPER_LATCH, 8'h5A);
      wr(ADDR_LOWER_BYTE, 8'h34);
      chk(program_counter_o, 15'h5A34, "low byte write");
      rd(ADDR_LOWER_BYTE, v);
      chk(v, 8'h34, "low byte read");
      $display("test low byte done");
      op(OP_CALL, 11'h123);
      chk(program_counter_o, 15'h5923, "call target");
      chk(stack_pointer_o, 5'h00, "pointer after call");
      rd(ADDR_STACK_TOP_LOWER, v);
      chk(v, 8'h35, "pushed low");
      rd(ADDR_STACK_TOP_UPPER, v);
      chk(v, 8'h5A, "pushed high");
      op(OP_COMPUTED_CALL, 11'h000);
      chk(program_counter_o, 15'h5A80, "computed call");
      op(OP_RETURN, 11'h000);
      chk(program_counter_o, 15'h5924, "return");
      op(OP_RETURN_WITH_LITERAL, 11'h000);
      chk(program_counter_o, 15'h5A35, "literal return");
      chk(stack_pointer_o, 5'h1F, "stack empty");
      chk(upper_counter_latch_o, 7'h5A, "latch kept");
      $display("test calls done");
      op(OP_RELATIVE_JUMP_BY_ACC, 11'h000);
      chk(program_counter_o, 15'h5AB6, "jump by acc");
      op(OP_RELATIVE_JUMP_LITERAL, 11'h100);
      chk(program_counter_o, 15'h59B7, "literal jump back");
      op(OP_INT_VECTOR, 11'h000);
      chk(program_counter_o, INT_VECTOR, "vector");
      op(OP_RETURN_FROM_INTERRUPT, 11'h000);
      chk(program_counter_o, 15'h59B7, "interrupt return");
      // Call and return on consecutive cycles
      op_i <= OP_CALL;
      operand_i <= 11'h044;
      op_valid_i <= 1'b1;
      @(posedge ref_clk_i);
      op_i <= OP_RETURN;
      @(posedge ref_clk_i);
      op_valid_i <= 1'b0;
      @(posedge ref_clk_i);
      #1;
      chk(program_counter_o, 15'h59B8, "back to back return");
      chk(stack_pointer_o, 5'h1F, "back to back pointer");
      $display("test jumps done");
      for (int i = 0; i < 16; i++) begin
         op(OP_CALL, 11'(i));
      end
      chk(stack_pointer_o, 5'h0F, "full stack");
      rd(ADDR_STACK_FLAGS, v);
      chk(v, 8'h00, "no overflow yet");
      op(OP_CALL, 11'h010);
      chk(stack_pointer_o, 5'h00, "pointer wraps");
      rd(ADDR_STACK_FLAGS, v);
      chk(v, 8'h01, "overflow flag");
      wr(ADDR_STACK_POINTER, 8'h00);
      rd(ADDR_STACK_TOP_LOWER, v);
      chk(v, 8'h10, "oldest overwritten");
      wr(ADDR_STACK_POINTER, 8'h03);
      rd(ADDR_STACK_TOP_LOWER, v);
      chk(v, 8'h03, "entry three");
      wr(ADDR_STACK_TOP_LOWER, 8'hAA);
      rd(ADDR_STACK_TOP_LOWER, v);
      chk(v, 8'hAA, "entry written");
      wr(ADDR_STACK_FLAGS, 8'h00);
      wr(ADDR_STACK_POINTER, 8'h1F);
      op(OP_RETURN, 11'h000);
      chk(program_counter_o, 15'h580F, "underflow pop");
      chk(stack_pointer_o, 5'h0E, "underflow wrap");
      rd(ADDR_STACK_FLAGS, v);
      chk(v, 8'h02, "underflow flag");
      chk(n_rst, 0, "no reset in circular mode");
      $display("test circular done");
      wr(ADDR_STACK_FLAGS, 8'h00);
      stack_fault_reset_en_i <= 1'b1;
      wr(ADDR_STACK_POINTER, 8'h1F);
      op(OP_RETURN, 11'h000);
      chk(program_counter_o, 15'h0000, "underflow reset");
      chk(stack_pointer_o, 5'h1F, "pointer reset");
      rd(ADDR_STACK_FLAGS, v);
      chk(v, 8'h02, "underflow flag");
      wr(ADDR_STACK_FLAGS, 8'h00);
      wr(ADDR_STACK_POINTER, 8'h0F);
      op(OP_CALL, 11'h055);
      chk(program_counter_o, 15'h0000, "overflow reset");
      rd(ADDR_STACK_FLAGS, v);
      chk(v, 8'h01, "overflow flag");
      chk(n_rst, 2, "reset pulses");
      stack_fault_reset_en_i <= 1'b0;
      $display("test fault reset done");
      alu(ALU_ADD, 8'hFF, 8'h01);
      chk(status_o, 5'h1F, "add carries");
      chk(alu_result_o, 8'h00, "add result");
      alu(ALU_SUB, 8'h05, 8'h06);
      chk(status_o, 5'h18, "sub borrow");
      alu(ALU_SUB, 8'h06, 8'h05);
      chk(status_o, 5'h1B, "sub no borrow");
      alu_op_i <= ALU_ADD;
      alu_a_i <= 8'h01;
      alu_b_i <= 8'h01;
      wr(ADDR_STATUS, 8'hFF);
      alu_op_i <= ALU_NONE;
      @(posedge ref_clk_i);
      #1;
      chk(status_o, 5'h18, "flags win over write");
      wr(ADDR_STATUS, 8'h05);
      chk(status_o, 5'h1D, "status write");
      wr(ADDR_STATUS, 8'h00);
      chk(status_o, 5'h18, "read-only bits kept");
      wdt_timeout_i <= 1'b1;
      @(posedge ref_clk_i);
      wdt_timeout_i <= 1'b0;
      wr(ADDR_STATUS, 8'hFF);
      chk(status_o, 5'h0F, "expiry bit not writable");
      sleep_i <= 1'b1;
      @(posedge ref_clk_i);
      sleep_i <= 1'b0;
      wr(ADDR_STATUS, 8'h18);
      chk(status_o, 5'h10, "sleep bit not writable");
      clrwdt_i <= 1'b1;
      @(posedge ref_clk_i);
      clrwdt_i <= 1'b0;
      @(posedge ref_clk_i);
      #1;
      chk(status_o, 5'h18, "power bits set again");
      alu(ALU_ADD, 8'h0F, 8'hF1);
      chk(status_o, 5'h1F, "add nibble and msb carry");
      logic_res_i <= 8'h3C;
      alu(ALU_LOGIC, 8'h00, 8'h00);
      chk(status_o, 5'h1B, "logic touches only null");
      chk(alu_result_o, 8'h3C, "logic result");
      $display("test status done");
      give_verdict();
   end

endmodule
